// file: scfp_defs.vh
// Shared constants for the serial command frame parser.
`ifndef SCFP_DEFS_VH
`define SCFP_DEFS_VH

// ----------------------------------------------------------------------
// Frame framing bytes and answers
// ----------------------------------------------------------------------
`define SCFP_FRAME_START_BYTE 8'h02
`define SCFP_FRAME_END_BYTE   8'h03
`define SCFP_ACK_BYTE         8'h06
`define SCFP_NAK_BYTE         8'h15

// ----------------------------------------------------------------------
// Second header byte layout
// ----------------------------------------------------------------------
`define SCFP_HDR_RW_BIT   7
`define SCFP_HDR_LEN_MSB  6
`define SCFP_HDR_LEN_LSB  0
`define SCFP_RW_WRITE     1'b0
`define SCFP_RW_READ      1'b1

// ----------------------------------------------------------------------
// Response sequence positions, counted from the start byte
// ----------------------------------------------------------------------
`define SCFP_RSP_POS_CODE 8'h01
`define SCFP_RSP_POS_HDR  8'h02
`define SCFP_RSP_POS_DATA 8'h03
`define SCFP_RSP_POS_END  8'h04
`define SCFP_RSP_ADDR_LAG 7'h02

// ----------------------------------------------------------------------
// Timing: clock rate and byte gap limits
// ----------------------------------------------------------------------
`define SCFP_CLK_KHZ      100000
`define SCFP_GAP_MS       1000
`define SCFP_SILENT_MS    1500
`define SCFP_TMR_W        28

// ----------------------------------------------------------------------
// Receive buffering and data store
// ----------------------------------------------------------------------
`define SCFP_FIFO_DEPTH   8
`define SCFP_FIFO_AW      3
`define SCFP_MEM_WORDS    128

`endif

// file: scfp_fifo.v
// Receive byte FIFO with valid and ready on both sides.
`timescale 1ns/1ns
`default_nettype none

module scfp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk_sys,
    input  wire             rst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output reg              in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);

    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0]    wr_ptr_r;
    reg  [AW-1:0]    rd_ptr_r;
    reg  [AW:0]      cnt_r;
    reg  [AW:0]      cnt_nxt;
    wire             push;
    wire             pop;

    // Handshakes on each side.
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr_r];

    // Occupancy after this cycle's push and pop.
    always @* begin
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    // Storage write; entries need no reset.
    always @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // Pointers, count and a registered ready that drops when full.
    always @(posedge clk_sys) begin
        if (rst) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            cnt_r    <= {(AW+1){1'b0}};
            in_ready <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            cnt_r    <= cnt_nxt;
            in_ready <= (cnt_nxt != DEPTH[AW:0]);
        end
    end

endmodule // scfp_fifo

`default_nettype wire

// file: scfp_gap_timer.v
// Byte gap timer: flags a long gap and a long silence on the line.
`timescale 1ns/1ns
`default_nettype none
`include "scfp_defs.vh"

module scfp_gap_timer #(
    parameter [`SCFP_TMR_W-1:0] GAP_CYC = 100000000,
    parameter [`SCFP_TMR_W-1:0] SIL_CYC = 150000000
) (
    input  wire clk_sys,
    input  wire rst,
    input  wire byte_seen,
    output reg  gap_over,
    output reg  silent
);

    reg [`SCFP_TMR_W-1:0] cnt_r;

    // Count cycles since the last byte, saturating at the silence limit.
    always @(posedge clk_sys) begin
        if (rst) begin
            cnt_r    <= {`SCFP_TMR_W{1'b0}};
            gap_over <= 1'b0;
            silent   <= 1'b0;
        end else if (byte_seen) begin
            cnt_r    <= {`SCFP_TMR_W{1'b0}};
            gap_over <= 1'b0;
            silent   <= 1'b0;
        end else begin
            if (cnt_r != SIL_CYC) begin
                cnt_r <= cnt_r + 1'b1;
            end
            gap_over <= (cnt_r >= GAP_CYC);   // R12
            silent   <= (cnt_r >= SIL_CYC - 1'b1);   // R13
        end
    end

endmodule // scfp_gap_timer

`default_nettype wire

// file: scfp_parser.v
// Serial command frame parser: checks frames, answers and executes them.
// Functional notes
// R1: Each frame opens with one start byte of value 02h.
// R2: Header holds 8-bit command code, read/write flag, 7-bit byte length.
// R3: First header byte is the code; flag is top bit of second byte.
// R4: Read frames carry no data; length gives bytes expected back.
// R5: Check byte is XOR of both header bytes and all data bytes.
// R6: Each frame ends with one end byte 03h right after check byte.
// R7: Each received frame is answered with 06h ack or 15h nak.
// R8: Multi-byte data values travel least significant byte first.
// R9: Device checks byte order, XOR check and data count on receipt.
// R10: Ack only when all checks pass; nak if any check fails.
// R11: Only a validated frame is executed.
// R12: A byte gap over one second inside a frame enters discard.
// R13: Discard lasts until 1.5 s of silence, then back to idle.
// R14: Valid known read gets ack plus a response frame with data.
// R15: Valid unknown read gets ack and no response frame.
// R16: Valid write gets only an ack, never a response frame.
// R17: Valid unknown write gets ack and changes no setting.
// R18: Write data is applied as given, without range checks.
// R19: Host assumes no device when a read gets no answer byte.
// R20: Host fails a read whose response misses 500 ms after ack.
// R21: Host may confirm a write by reading it back.
// R22: After a nak the frame is dropped and the device idles.
// R23: Non-start bytes in idle are ignored without any answer.
`timescale 1ns/1ns
`default_nettype none
`include "scfp_defs.vh"

module scfp_parser #(
    parameter [`SCFP_TMR_W-1:0] GAP_CYC = `SCFP_GAP_MS * `SCFP_CLK_KHZ,
    parameter [`SCFP_TMR_W-1:0] SIL_CYC = `SCFP_SILENT_MS * `SCFP_CLK_KHZ
) (
    input  wire       clk_sys,
    input  wire       rst,
    input  wire [7:0] rx_data,
    input  wire       rx_valid,
    output wire       rx_ready,
    output reg  [7:0] tx_data,
    output reg        tx_valid,
    input  wire       tx_ready,
    output reg  [7:0] cmd_code,
    output reg  [6:0] cmd_len,
    output reg        cmd_is_read,
    input  wire       code_known,
    output reg  [6:0] rd_addr,
    input  wire [7:0] rd_byte,
    output reg        wr_valid,
    output reg  [6:0] wr_addr,
    output reg  [7:0] wr_data,
    output reg        wr_commit,
    output reg        frame_ok,
    output reg        frame_bad,
    output reg        discarding
);

    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'b0000;
    localparam [3:0] ST_CODE = 4'b0001;
    localparam [3:0] ST_LEN  = 4'b0010;
    localparam [3:0] ST_DATA = 4'b0011;
    localparam [3:0] ST_CHK  = 4'b0100;
    localparam [3:0] ST_END  = 4'b0101;
    localparam [3:0] ST_ACK  = 4'b0110;
    localparam [3:0] ST_WR   = 4'b0111;
    localparam [3:0] ST_RSP  = 4'b1000;
    localparam [3:0] ST_DROP = 4'b1001;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    reg  [7:0] data_mem [0:`SCFP_MEM_WORDS-1];
    reg  [3:0] state_r;
    reg  [7:0] xor_r;
    reg  [7:0] idx_r;
    reg        ok_r;
    reg        known_r;
    reg  [7:0] rsp_byte;
    wire [7:0] fifo_data;
    wire       fifo_valid;
    wire       pop_en;
    wire       pop;
    wire       in_frame;
    wire       gap_over;
    wire       silent;
    wire [7:0] len_ext;

    // Bytes are drained only while parsing or discarding; answering
    // stalls the FIFO so that back-pressure reaches the line.
    assign pop_en   = (state_r <= ST_END) || (state_r == ST_DROP);
    assign pop      = pop_en && fifo_valid;
    assign in_frame = (state_r >= ST_CODE) && (state_r <= ST_END);
    assign len_ext  = {1'b0, cmd_len};

    // ------------------------------------------------------------------
    // Receive buffering and gap timing
    // ------------------------------------------------------------------
    scfp_fifo #(
        .WIDTH (8),
        .DEPTH (`SCFP_FIFO_DEPTH),
        .AW    (`SCFP_FIFO_AW)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_data   (rx_data),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (pop_en)
    );

    // The gap is timed at the line side, where bytes really arrive.
    scfp_gap_timer #(
        .GAP_CYC (GAP_CYC),
        .SIL_CYC (SIL_CYC)
    ) u_timer (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .byte_seen (rx_valid && rx_ready),
        .gap_over  (gap_over),
        .silent    (silent)
    );

    // ------------------------------------------------------------------
    // Response byte selection
    // ------------------------------------------------------------------
    // Picks the next byte of the response frame by its position.
    always @* begin
        if (idx_r == 8'h00) begin
            rsp_byte = `SCFP_FRAME_START_BYTE;   // R1
        end else if (idx_r == `SCFP_RSP_POS_CODE) begin
            rsp_byte = cmd_code;
        end else if (idx_r == `SCFP_RSP_POS_HDR) begin
            rsp_byte = {`SCFP_RW_WRITE, cmd_len};   // R2
        end else if (idx_r == len_ext + `SCFP_RSP_POS_DATA) begin
            rsp_byte = xor_r;   // R5
        end else if (idx_r == len_ext + `SCFP_RSP_POS_END) begin
            rsp_byte = `SCFP_FRAME_END_BYTE;   // R6
        end else begin
            rsp_byte = rd_byte;   // R8
        end
    end

    // Data bytes of a write frame are kept until the frame is validated.
    always @(posedge clk_sys) begin
        if (pop && state_r == ST_DATA) begin
            data_mem[idx_r[6:0]] <= fifo_data;
        end
    end

    // ------------------------------------------------------------------
    // Main sequencer
    // ------------------------------------------------------------------
    // Parses, executes and discards one byte per cycle; each answer byte takes at least two cycles.
    always @(posedge clk_sys) begin
        if (rst) begin
            state_r     <= ST_IDLE;
            xor_r       <= 8'h00;
            idx_r       <= 8'h00;
            ok_r        <= 1'b0;
            known_r     <= 1'b0;
            tx_data     <= 8'h00;
            tx_valid    <= 1'b0;
            cmd_code    <= 8'h00;
            cmd_len     <= 7'h00;
            cmd_is_read <= 1'b0;
            rd_addr     <= 7'h00;
            wr_valid    <= 1'b0;
            wr_addr     <= 7'h00;
            wr_data     <= 8'h00;
            wr_commit   <= 1'b0;
            frame_ok    <= 1'b0;
            frame_bad   <= 1'b0;
            discarding  <= 1'b0;
        end else begin
            wr_valid   <= 1'b0;
            wr_commit  <= 1'b0;
            frame_ok   <= 1'b0;
            frame_bad  <= 1'b0;
            discarding <= (state_r == ST_DROP);
            if (in_frame && gap_over && !fifo_valid) begin
                state_r    <= ST_DROP;   // R12
                discarding <= 1'b1;
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        // Anything but a start byte is silently dropped.
                        if (pop && fifo_data == `SCFP_FRAME_START_BYTE) begin
                            state_r <= ST_CODE;   // R1 R23
                            xor_r   <= 8'h00;
                            ok_r    <= 1'b1;
                        end
                    end
                    ST_CODE: begin
                        if (pop) begin
                            cmd_code <= fifo_data;   // R3
                            xor_r    <= xor_r ^ fifo_data;   // R5
                            state_r  <= ST_LEN;
                        end
                    end
                    ST_LEN: begin
                        if (pop) begin
                            cmd_is_read <= fifo_data[`SCFP_HDR_RW_BIT];   // R3
                            cmd_len     <= fifo_data[`SCFP_HDR_LEN_MSB:
                                                     `SCFP_HDR_LEN_LSB];
                            xor_r       <= xor_r ^ fifo_data;   // R5
                            idx_r       <= 8'h00;
                            // Reads carry no data; the length is the reply.
                            if (fifo_data[`SCFP_HDR_RW_BIT] == `SCFP_RW_WRITE
                                && fifo_data[`SCFP_HDR_LEN_MSB:
                                             `SCFP_HDR_LEN_LSB] != 7'h00) begin
                                state_r <= ST_DATA;   // R2
                            end else begin
                                state_r <= ST_CHK;   // R4
                            end
                        end
                    end
                    ST_DATA: begin
                        if (pop) begin
                            xor_r <= xor_r ^ fifo_data;   // R5
                            idx_r <= idx_r + 8'h01;
                            if (idx_r == len_ext - 8'h01) begin
                                state_r <= ST_CHK;   // R9
                            end
                        end
                    end
                    ST_CHK: begin
                        if (pop) begin
                            if (fifo_data != xor_r) begin
                                ok_r <= 1'b0;   // R5 R9
                            end
                            state_r <= ST_END;
                        end
                    end
                    ST_END: begin
                        // A misplaced end byte means a count or order error.
                        if (pop) begin
                            if (fifo_data != `SCFP_FRAME_END_BYTE) begin
                                ok_r <= 1'b0;   // R6 R9
                            end
                            state_r <= ST_ACK;
                        end
                    end
                    ST_ACK: begin
                        // One answer byte per frame, held until taken.
                        if (!tx_valid) begin
                            tx_data  <= ok_r ? `SCFP_ACK_BYTE
                                             : `SCFP_NAK_BYTE;   // R7 R10
                            tx_valid <= 1'b1;
                            known_r  <= code_known;
                        end else if (tx_ready) begin
                            tx_valid  <= 1'b0;
                            idx_r     <= 8'h00;
                            xor_r     <= 8'h00;
                            frame_ok  <= ok_r;
                            frame_bad <= !ok_r;
                            if (!ok_r || !known_r) begin
                                state_r <= ST_IDLE;   // R22 R15 R17
                            end else if (cmd_is_read) begin
                                state_r <= ST_RSP;   // R14
                            end else begin
                                state_r <= ST_WR;   // R11 R16
                            end
                        end
                    end
                    ST_WR: begin
                        // Stored bytes go out unchanged, then a commit.
                        if (idx_r < len_ext) begin
                            wr_valid <= 1'b1;   // R18
                            wr_addr  <= idx_r[6:0];
                            wr_data  <= data_mem[idx_r[6:0]];
                            idx_r    <= idx_r + 8'h01;
                        end else begin
                            wr_commit <= 1'b1;   // R11
                            state_r   <= ST_IDLE;
                        end
                    end
                    ST_RSP: begin
                        // Response frame: start, header, data, check, end.
                        if (!tx_valid) begin
                            tx_data  <= rsp_byte;   // R14
                            tx_valid <= 1'b1;
                        end else if (tx_ready) begin
                            tx_valid <= 1'b0;
                            if (idx_r != 8'h00
                                && idx_r < len_ext + `SCFP_RSP_POS_DATA) begin
                                xor_r <= xor_r ^ tx_data;   // R5
                            end
                            if (idx_r == len_ext + `SCFP_RSP_POS_END) begin
                                state_r <= ST_IDLE;
                            end else begin
                                idx_r   <= idx_r + 8'h01;
                                rd_addr <= idx_r[6:0] - `SCFP_RSP_ADDR_LAG;
                            end
                        end
                    end
                    ST_DROP: begin
                        // Bytes are drained and ignored until silence.
                        if (silent) begin
                            state_r <= ST_IDLE;   // R13
                        end
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule // scfp_parser

`default_nettype wire

// file: scfp_parser_chk.sv
// Port checker for the serial command frame parser, bound to its top.
`timescale 1ns/1ns
`default_nettype none
module scfp_parser_chk (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic [7:0] tx_data,
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic       wr_valid,
    input wire logic [6:0] wr_addr,
    input wire logic       wr_commit,
    input wire logic       frame_ok,
    input wire logic       frame_bad,
    input wire logic       discarding
);
    // All checks run on the system clock and sleep during reset.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    ack_byte_a:
    assert property (frame_ok |-> $past(tx_valid && tx_ready)
                     && $past(tx_data) == 8'h06)
        else $error("frame_ok without an ack byte taken");
    nak_byte_a:
    assert property (frame_bad |-> $past(tx_valid && tx_ready)
                     && $past(tx_data) == 8'h15)
        else $error("frame_bad without a nak byte taken");
    tx_hold_a:
    assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("answer byte dropped before taken");
    tx_bubble_a:
    assert property (tx_valid && tx_ready |=> !tx_valid)
        else $error("no idle cycle between answer bytes");
    wr_after_ack_a:
    assert property ($rose(wr_valid) |-> frame_ok || $past(frame_ok))
        else $error("write data without an ack");
    commit_cause_a:
    assert property (wr_commit |-> $past(wr_valid) || frame_ok
                     || $past(frame_ok))
        else $error("commit without a validated write");
    commit_end_a:
    assert property ($fell(wr_valid) |-> wr_commit)
        else $error("last write byte not followed by commit");
    wr_index_a:
    assert property (wr_valid && $past(wr_valid) |->
                     wr_addr == $past(wr_addr) + 7'h01)
        else $error("write byte index not ascending");
    nak_quiet_a:
    assert property (frame_bad |=> (!wr_valid && !wr_commit) [*4])
        else $error("write activity after a nak");
    discard_mute_a:
    assert property (discarding |-> !tx_valid)
        else $error("answer sent while discarding");

    // Main scenarios seen at least once.
    cover property (frame_ok);
    cover property (frame_bad);
    cover property ($fell(discarding));
    cover property (wr_commit);
endmodule // scfp_parser_chk

bind scfp_parser scfp_parser_chk i_chk (
    .clk_sys(clk_sys), .rst(rst), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .wr_valid(wr_valid), .wr_addr(wr_addr),
    .wr_commit(wr_commit), .frame_ok(frame_ok), .frame_bad(frame_bad),
    .discarding(discarding)
);
`default_nettype wire

// file: scfp_host_model.sv
// Host-side model: sends queued bytes and collects answer bytes.
`timescale 1ns/1ns
`default_nettype none
module scfp_host_model (
    input  wire logic       clk_sys,
    output wire logic [7:0] rx_data,
    output wire logic       rx_valid,
    input  wire logic       rx_ready,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output wire logic       tx_ready,
    input  wire logic       slow
);
    logic [7:0] send_q [$];
    logic [7:0] got_q  [$];
    logic [7:0] data_r  = 8'h00;
    logic       valid_r = 1'h0;
    logic       ready_r = 1'h0;
    logic [1:0] tick_r  = 2'h0;

    assign rx_data  = data_r;
    assign rx_valid = valid_r;
    assign tx_ready = ready_r;

    // Bytes change hands only at the rising edge.
    always @(posedge clk_sys) begin
        if (rx_valid && rx_ready)
            void'(send_q.pop_front());
        if (tx_valid && tx_ready)
            got_q.push_back(tx_data);
    end

    // Offer the head byte until taken; an idle line shows the inverse.
    always @(negedge clk_sys) begin
        tick_r  <= tick_r + 2'h1;
        ready_r <= !slow || tick_r == 2'h3;
        if (send_q.size() != 0) begin
            valid_r <= 1'h1;
            data_r  <= send_q[0];
        end else begin
            valid_r <= 1'h0;
            data_r  <= ~data_r;
        end
    end
endmodule // scfp_host_model
`default_nettype wire

// file: scfp_parser_test.sv
// Self-checking testbench for the serial command frame parser.
`timescale 1ns/1ns
`default_nettype none
module scfp_parser_test;
    logic       clk_sys, rst, slow, code_known, tx_ready, rx_valid;
    logic [7:0] rx_data, tx_data, cmd_code, rd_byte, wr_data;
    logic [6:0] cmd_len, rd_addr, wr_addr;
    logic       rx_ready, tx_valid, cmd_is_read, wr_valid, wr_commit;
    logic       frame_ok, frame_bad, discarding;
    logic [7:0] stage [0:127];
    logic       saw_full = 1'h0;
    int         error_cnt = 0;
    int         n_checks = 0;
    int         commits = 0;
    int         wr_n = 0;

    scfp_parser #(.GAP_CYC(40), .SIL_CYC(60)) i_dut (
        .clk_sys(clk_sys), .rst(rst), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .cmd_code(cmd_code),
        .cmd_len(cmd_len), .cmd_is_read(cmd_is_read),
        .code_known(code_known), .rd_addr(rd_addr), .rd_byte(rd_byte),
        .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
        .wr_commit(wr_commit), .frame_ok(frame_ok), .frame_bad(frame_bad),
        .discarding(discarding));
    scfp_host_model i_host (
        .clk_sys(clk_sys), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .slow(slow));

    // Clock at 100 MHz.
    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end

    // User settings store: two known codes, data kept LSB first.
    assign code_known = (cmd_code === 8'h43) || (cmd_code === 8'h46);
    assign rd_byte    = stage[rd_addr];
    always @(posedge clk_sys) begin
        if (wr_valid === 1'h1) begin
            stage[wr_addr] <= wr_data;
            wr_n <= wr_n + 1;
        end
        if (wr_commit === 1'h1)
            commits <= commits + 1;
        if (!rst && rx_valid && !rx_ready && wr_n > 0)
            saw_full <= 1'h1;
    end

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic ok, input string what);
        n_checks++;
        if (ok !== 1'h1) begin
            error_cnt++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask

    // Queue one frame: start, header and data, check byte, end byte.
    task automatic send(input logic [7:0] b[$], input logic [7:0] fx, fe);
        logic [7:0] x;
        x = fx;
        foreach (b[i]) x = x ^ b[i];
        i_host.send_q.push_back(8'h02);
        foreach (b[i]) i_host.send_q.push_back(b[i]);
        i_host.send_q.push_back(x);
        i_host.send_q.push_back(8'h03 ^ fe);
    endtask

    // Wait a bounded time for each answer byte and compare it.
    task automatic exp(input logic [7:0] e[$]);
        int k;
        foreach (e[i]) begin
            for (k = 0; k < 200 && i_host.got_q.size() == 0; k++)
                @(negedge clk_sys);
            if (k == 200) begin
                chk(1'h0, "answer byte missing");
                give_verdict();
            end else begin
                chk(i_host.got_q.pop_front() === e[i], "answer byte value");
            end
        end
    endtask

    initial begin
        int k;
        int c;
        rst  = 1'h1;
        slow = 1'h0;
        foreach (stage[i]) stage[i] = 8'h00;
        repeat (8) @(negedge clk_sys);
        rst = 1'h0;
        send({8'h46, 8'h01, 8'h02}, 8'h00, 8'h00);
        exp({8'h06});
        repeat (5) @(negedge clk_sys);
        chk(wr_n == 1 && stage[0] === 8'h02 && commits == 1, "w1");
        chk(cmd_len === 7'h01 && cmd_is_read === 1'h0, "hdr");
        send({8'h46, 8'h02, 8'hA5, 8'h5A}, 8'h00, 8'h00);
        exp({8'h06});
        slow = 1'h1;
        send({8'h43, 8'h82}, 8'h00, 8'h00);
        send({8'h46, 8'h04, 8'h11, 8'h22, 8'h33, 8'h44}, 8'h00, 8'h00);
        exp({8'h06, 8'h02, 8'h43, 8'h02, 8'hA5, 8'h5A,
             8'h43 ^ 8'h02 ^ 8'hA5 ^ 8'h5A, 8'h03});
        exp({8'h06});
        slow = 1'h0;
        repeat (8) @(negedge clk_sys);
        chk(saw_full === 1'h1 && stage[2] === 8'h33
            && stage[3] === 8'h44, "fifo full");
        c = commits;
        send({8'h46, 8'h01, 8'h77}, 8'h01, 8'h00);
        exp({8'h15});
        send({8'h46, 8'h01, 8'h77}, 8'h00, 8'h04);
        exp({8'h15});
        send({8'h99, 8'h81}, 8'h00, 8'h00);
        exp({8'h06});
        chk(cmd_is_read === 1'h1 && cmd_code === 8'h99, "rd hdr");
        send({8'h99, 8'h01, 8'h77}, 8'h00, 8'h00);
        exp({8'h06});
        i_host.send_q.push_back(8'h55);
        i_host.send_q.push_back(8'h03);
        repeat (30) @(negedge clk_sys);
        chk(i_host.got_q.size() == 0 && commits == c
            && stage[0] === 8'h11, "quiet");
        i_host.send_q.push_back(8'h02);
        i_host.send_q.push_back(8'h46);
        for (k = 0; k < 200 && discarding !== 1'h1; k++)
            @(negedge clk_sys);
        chk(discarding === 1'h1 && k > 35, "discard entry");
        i_host.send_q.push_back(8'h12);
        for (k = 0; k < 300 && discarding !== 1'h0; k++)
            @(negedge clk_sys);
        chk(k > 50 && k < 300, "discard exit");
        chk(i_host.got_q.size() == 0, "no answer");
        send({8'h46, 8'h01, 8'h02}, 8'h00, 8'h00);
        exp({8'h06});
        give_verdict();
    end
endmodule // scfp_parser_test
`default_nettype wire
